/* rtl/dcm_top.v */
// data-cache class invalidate and debug read engine
//
// Notes on behaviour
// - address is base (or zero) plus index
// - invalidate clears both ways of class
// - invalidate ignores cachability and hit state
// - dirty lines discarded, never written back
// - user mode gives program exception instead
// - relocation: zone protection faults invalidate
// - user attribute with enable faults invalidate
// - relocation: missing translation faults invalidate
// - invalidate checked as a store
// - neither operation raises address-compare debug
// - nonzero reserved bits never cause program exception
// - class from address, way from config bit
// - cache_field_a bit picks word or tag
// - cache_field_a high, dirty and valid placed
// - reserved bits zero, lru in bit 0
// - read faults unless word aligned
// - read checked as load, never storage fault
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "dcm_consts.vh"

module dcm_top (
   input  wire         clock,          // core clock, 50 MHz
   input  wire         arst_n,         // async reset, active low
   // ==========================================================
   // register port
   input  wire [7:0]   reg_addr,       // byte address
   input  wire [31:0]  reg_wdata,      // write data
   input  wire         reg_wr,         // write strobe
   input  wire         reg_rd,         // read strobe
   output reg  [31:0]  reg_rdata_q,    // read data, cycle after strobe
   // ==========================================================
   // pipeline issue and completion
   input  wire         op_valid,       // instruction offered
   input  wire [31:0]  op_instr,       // instruction word
   input  wire [31:0]  op_base_val,    // contents of base register
   input  wire [31:0]  op_index_val,   // contents of index register
   input  wire         op_user_mode,   // issued in user mode
   input  wire         op_reloc_en,    // data relocation enabled
   output reg          busy_q,         // operation in flight
   output reg          done_q,         // completion pulse
   output reg          exc_program_q,  // program exception
   output reg          exc_align_q,    // alignment exception
   output reg          exc_dstor_q,    // data-storage exception
   output reg          exc_dtlb_q,     // data tlb-miss exception
   output reg          dest_we_q,      // write destination register
   output reg  [4:0]   dest_idx_q,     // destination register number
   output reg  [31:0]  dest_data_q,    // destination value
   // ==========================================================
   // translation lookup, answer one cycle after request
   output reg          xlat_req_q,     // lookup request pulse
   output reg  [31:0]  xlat_ea_q,      // effective_address looked up
   output reg          xlat_store_q,   // access classed as store
   input  wire         xlat_hit,       // valid translation found
   input  wire         xlat_no_access, // no-access zone
   input  wire         xlat_read_only, // read-only zone
   input  wire         xlat_user_attr, // user_defined_attr of page
   // ==========================================================
   // data/tag array read, data one cycle after request
   output reg          arr_rd_q,       // array read pulse
   output reg  [7:0]   arr_class_q,    // congruence class
   output reg          arr_way_q,      // 0 way a, 1 way b
   output reg  [2:0]   arr_word_q,     // word in line
   output reg          arr_tag_q,      // 1 reads tag, 0 reads word
   input  wire [18:0]  arr_rdata,      // cache_field_a from array
   // ==========================================================
   // status updates from normal cache operation
   input  wire         upd_we,         // status write
   input  wire [7:0]   upd_class,      // class updated
   input  wire [4:0]   upd_mask,       // status bits written
   input  wire [4:0]   upd_bits        // status values
);

   // ==========================================================
   // states
   localparam [4:0] S_IDLE = 5'h01;
   localparam [4:0] S_XLAT = 5'h02;
   localparam [4:0] S_CHK  = 5'h04;
   localparam [4:0] S_RDW  = 5'h08;
   localparam [4:0] S_CAP  = 5'h10;

   reg  [4:0]   state_q;
   reg          op_read_q;
   reg  [31:0]  ea_q;
   reg          user_q;
   reg          reloc_q;
   reg          way_q;
   reg          uxe_q;
   // core_config_reg
   reg          way_select_bit_q;
   reg          cache_field_a_select_bit_q;
   reg          user_attr_exc_enable_q;
   reg  [3:0]   last_exc_q;
   reg  [15:0]  op_cnt_q;

   // ==========================================================
   // decode; reserved fields are not examined, except bit 0, which must be zero
   wire [5:0]  opc     = op_instr[`DCM_OPC_HI:`DCM_OPC_LO];
   wire [9:0]  xo      = op_instr[`DCM_XO_HI:`DCM_XO_LO];
   wire        form_ok = (opc == `DCM_OPC_PRI) && !op_instr[`DCM_LAST];
   wire        dec_inv = form_ok && (xo == `DCM_XO_INV);
   wire        dec_rd  = form_ok && (xo == `DCM_XO_READ);
   wire        accept  = op_valid && state_q[0] && (dec_inv || dec_rd);

   // ==========================================================
   // effective address
   wire [4:0]  base_fld = op_instr[`DCM_RA_HI:`DCM_RA_LO];
   wire [31:0] base     = (base_fld == 5'h00) ? 32'h0 : op_base_val;
   wire [31:0] ea       = base + op_index_val;
   wire        misalign = (ea[`DCM_EA_ALN_HI:`DCM_EA_ALN_LO] != 2'h0);

   // ==========================================================
   // data-access checks, sampled in the check state
   wire tlb_miss   = reloc_q && !xlat_hit;
   wire zone_fault = reloc_q && ((xlat_no_access && user_q) || xlat_read_only);
   wire attr_fault = xlat_user_attr && uxe_q;
   // a read never takes the storage fault, only the tlb miss
   wire stor_fault = !op_read_q && !tlb_miss && (zone_fault || attr_fault);
   wire chk_ok     = !tlb_miss && !stor_fault;

   // ==========================================================
   // status memory: invalidate write has priority over updates
   wire       inv_we   = state_q[2] && !op_read_q && chk_ok;
   wire       st_we    = inv_we || upd_we;
   wire [7:0] ea_class = ea_q[`DCM_EA_CLS_HI:`DCM_EA_CLS_LO];
   wire [7:0] st_waddr = inv_we ? ea_class : upd_class;
   // valid and dirty of both ways drop; lru survives, no write-back
   wire [4:0] st_wmask = inv_we ? `DCM_ST_INV_MASK : upd_mask;
   wire [4:0] st_wdata = inv_we ? 5'h00 : upd_bits;
   wire       st_re    = state_q[2] && op_read_q && chk_ok;
   wire [4:0] st_rdata;

   dcm_stat_ram u_stat (
      .clock  (clock),
      .arst_n (arst_n),
      .we     (st_we),
      .waddr  (st_waddr),
      .wmask  (st_wmask),
      .wdata  (st_wdata),
      .re     (st_re),
      .raddr  (ea_class),
      .rdata  (st_rdata)
   );

   // ==========================================================
   // result word of a cache read
   wire        sel_valid = way_q ? st_rdata[`DCM_ST_VB] : st_rdata[`DCM_ST_VA];
   wire        sel_dirty = way_q ? st_rdata[`DCM_ST_DB] : st_rdata[`DCM_ST_DA];
   reg  [31:0] result;

   always @* begin
      result = 32'h0;
      result[`DCM_RES_CACHE_FIELD_A_HI:`DCM_RES_CACHE_FIELD_A_LO] = arr_rdata;
      result[`DCM_RES_DIRTY] = sel_dirty;
      result[`DCM_RES_VALID] = sel_valid;
      result[`DCM_RES_LRU]   = st_rdata[`DCM_ST_LRU];
   end

   // ==========================================================
   // operation sequencer
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_q       <= S_IDLE;
         op_read_q     <= 1'b0;
         ea_q          <= 32'h0;
         user_q        <= 1'b0;
         reloc_q       <= 1'b0;
         way_q         <= 1'b0;
         uxe_q         <= 1'b0;
         busy_q        <= 1'b0;
         done_q        <= 1'b0;
         exc_program_q <= 1'b0;
         exc_align_q   <= 1'b0;
         exc_dstor_q   <= 1'b0;
         exc_dtlb_q    <= 1'b0;
         dest_we_q     <= 1'b0;
         dest_idx_q    <= 5'h00;
         dest_data_q   <= 32'h0;
         xlat_req_q    <= 1'b0;
         xlat_ea_q     <= 32'h0;
         xlat_store_q  <= 1'b0;
         arr_rd_q      <= 1'b0;
         arr_class_q   <= 8'h00;
         arr_way_q     <= 1'b0;
         arr_word_q    <= 3'h0;
         arr_tag_q     <= 1'b0;
         last_exc_q    <= 4'h0;
         op_cnt_q      <= 16'h0000;
      end else begin
         // pulses default low
         done_q        <= 1'b0;
         exc_program_q <= 1'b0;
         exc_align_q   <= 1'b0;
         exc_dstor_q   <= 1'b0;
         exc_dtlb_q    <= 1'b0;
         dest_we_q     <= 1'b0;
         xlat_req_q    <= 1'b0;
         arr_rd_q      <= 1'b0;
         case (state_q)
            S_IDLE: begin
               if (accept) begin
                  op_read_q  <= dec_rd;
                  ea_q       <= ea;
                  user_q     <= op_user_mode;
                  reloc_q    <= op_reloc_en;
                  // config is sampled once so a mid-flight write cannot split it
                  way_q      <= way_select_bit_q;
                  uxe_q      <= user_attr_exc_enable_q;
                  arr_tag_q  <= cache_field_a_select_bit_q;
                  dest_idx_q <= op_instr[`DCM_RD_HI:`DCM_RD_LO];
                  if (op_user_mode) begin
                     // privileged: refused before any lookup
                     done_q        <= 1'b1;
                     exc_program_q <= 1'b1;
                     last_exc_q    <= 4'h1;
                  end else if (dec_rd && misalign) begin
                     done_q      <= 1'b1;
                     exc_align_q <= 1'b1;
                     last_exc_q  <= 4'h2;
                  end else begin
                     // lookup carries no address-compare request
                     busy_q       <= 1'b1;
                     xlat_req_q   <= 1'b1;
                     xlat_ea_q    <= ea;
                     xlat_store_q <= dec_inv;
                     state_q      <= S_XLAT;
                  end
               end
            end
            S_XLAT: begin
               state_q <= S_CHK;
            end
            S_CHK: begin
               if (!chk_ok) begin
                  busy_q      <= 1'b0;
                  done_q      <= 1'b1;
                  exc_dtlb_q  <= tlb_miss;
                  exc_dstor_q <= stor_fault;
                  last_exc_q  <= {tlb_miss, stor_fault, 2'h0};
                  state_q     <= S_IDLE;
               end else if (op_read_q) begin
                  arr_rd_q    <= 1'b1;
                  arr_class_q <= ea_class;
                  arr_way_q   <= way_q;
                  arr_word_q  <= ea_q[`DCM_EA_WRD_HI:`DCM_EA_WRD_LO];
                  state_q     <= S_RDW;
               end else begin
                  // status cleared this cycle through inv_we
                  busy_q     <= 1'b0;
                  done_q     <= 1'b1;
                  last_exc_q <= 4'h0;
                  op_cnt_q   <= op_cnt_q + 16'h0001;
                  state_q    <= S_IDLE;
               end
            end
            S_RDW: begin
               state_q <= S_CAP;
            end
            S_CAP: begin
               // only the destination is written; status memory untouched
               busy_q      <= 1'b0;
               done_q      <= 1'b1;
               dest_we_q   <= 1'b1;
               dest_data_q <= result;
               last_exc_q  <= 4'h0;
               op_cnt_q    <= op_cnt_q + 16'h0001;
               state_q     <= S_IDLE;
            end
            default: begin
               busy_q  <= 1'b0;
               state_q <= S_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // register port
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         way_select_bit_q       <= |(`DCM_CFG_RST & (3'h1 << `DCM_CFG_WAY));
         cache_field_a_select_bit_q      <= |(`DCM_CFG_RST & (3'h1 << `DCM_CFG_CACHE_FIELD_A));
         user_attr_exc_enable_q <= |(`DCM_CFG_RST & (3'h1 << `DCM_CFG_UXE));
         reg_rdata_q            <= 32'h0;
      end else begin
         reg_rdata_q <= 32'h0;
         if (reg_wr && (reg_addr == `DCM_OFS_CFG)) begin
            way_select_bit_q       <= reg_wdata[`DCM_CFG_WAY];
            cache_field_a_select_bit_q      <= reg_wdata[`DCM_CFG_CACHE_FIELD_A];
            user_attr_exc_enable_q <= reg_wdata[`DCM_CFG_UXE];
         end
         if (reg_rd) begin
            case (reg_addr)
               `DCM_OFS_CFG: begin
                  reg_rdata_q[`DCM_CFG_WAY]  <= way_select_bit_q;
                  reg_rdata_q[`DCM_CFG_CACHE_FIELD_A] <= cache_field_a_select_bit_q;
                  reg_rdata_q[`DCM_CFG_UXE]  <= user_attr_exc_enable_q;
               end
               `DCM_OFS_STAT: begin
                  reg_rdata_q[`DCM_STAT_BUSY] <= busy_q;
                  reg_rdata_q[`DCM_STAT_EXC_HI:`DCM_STAT_EXC_LO] <= last_exc_q;
                  reg_rdata_q[`DCM_STAT_CNT_HI:`DCM_STAT_CNT_LO] <= op_cnt_q;
               end
               default: begin
                  // unmapped addresses read as zero
                  reg_rdata_q <= 32'h0;
               end
            endcase
         end
      end
   end

endmodule

/* rtl/dcm_consts.vh */
// constants of the data-cache class maintenance block
`ifndef DCM_CONSTS_VH
`define DCM_CONSTS_VH

// ==========================================================
// register port offsets and reset values
`define DCM_OFS_CFG      8'h00
`define DCM_OFS_STAT     8'h04
`define DCM_CFG_RST      3'h0
`define DCM_CFG_WAY      0
`define DCM_CFG_CACHE_FIELD_A     1
`define DCM_CFG_UXE      2
`define DCM_STAT_BUSY    0
`define DCM_STAT_EXC_LO  1
`define DCM_STAT_EXC_HI  4
`define DCM_STAT_CNT_LO  8
`define DCM_STAT_CNT_HI  23

// ==========================================================
// instruction fields (bit 31 of the word is the msb)
`define DCM_OPC_HI       31
`define DCM_OPC_LO       26
`define DCM_RD_HI        25
`define DCM_RD_LO        21
`define DCM_RA_HI        20
`define DCM_RA_LO        16
`define DCM_XO_HI        10
`define DCM_XO_LO        1
`define DCM_LAST         0
`define DCM_OPC_PRI      6'h1F
`define DCM_XO_INV       10'h1C6
`define DCM_XO_READ      10'h1E6

// ==========================================================
// effective address fields
`define DCM_EA_CLS_HI    12
`define DCM_EA_CLS_LO    5
`define DCM_EA_WRD_HI    4
`define DCM_EA_WRD_LO    2
`define DCM_EA_ALN_HI    1
`define DCM_EA_ALN_LO    0

// ==========================================================
// result word layout
`define DCM_RES_CACHE_FIELD_A_HI  31
`define DCM_RES_CACHE_FIELD_A_LO  13
`define DCM_RES_DIRTY    5
`define DCM_RES_VALID    4
`define DCM_RES_LRU      0

// ==========================================================
// line status entry: valid a/b, dirty a/b, lru
`define DCM_ST_VA        0
`define DCM_ST_VB        1
`define DCM_ST_DA        2
`define DCM_ST_DB        3
`define DCM_ST_LRU       4
`define DCM_ST_INV_MASK  5'h0F
`define DCM_ST_W         5
`define DCM_CLASSES      256

`endif

/* rtl/dcm_stat_ram.v */
// line status memory: per-bit write mask, registered read
`timescale 1ns/1ps
`include "dcm_consts.vh"

module dcm_stat_ram (
   input  wire                  clock,   // core clock
   input  wire                  arst_n,  // async reset, active low
   input  wire                  we,      // write strobe
   input  wire [7:0]            waddr,   // class written
   input  wire [`DCM_ST_W-1:0]  wmask,   // bits written
   input  wire [`DCM_ST_W-1:0]  wdata,   // write data
   input  wire                  re,      // read strobe
   input  wire [7:0]            raddr,   // class read
   output wire [`DCM_ST_W-1:0]  rdata    // read data, held until next read
);

   genvar i;
   generate
      for (i = 0; i < `DCM_ST_W; i = i + 1) begin : g_bit
         reg mem [0:`DCM_CLASSES-1];
         reg rd_q;
         always @(posedge clock) begin
            if (we && wmask[i]) begin
               mem[waddr] <= wdata[i];
            end
         end
         always @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
               rd_q <= 1'b0;
            end else if (re) begin
               // a write and a read of the same class in one cycle return the old bit
               rd_q <= mem[raddr];
            end
         end
         assign rdata[i] = rd_q;
      end
   endgenerate

endmodule

/* tb/dcm_far_model.sv */
// far-side model: translation lookup and cache array answers
`timescale 1ns/1ps

module dcm_far_model (
   input  wire        clock,       // core clock
   input  wire        arst_n,      // reset, low
   input  wire        xlat_req_q,  // lookup request
   input  wire        arr_rd_q,    // array read
   input  wire [7:0]  arr_class_q, // class
   input  wire        arr_way_q,   // way
   input  wire [2:0]  arr_word_q,  // word
   input  wire        arr_tag_q,   // tag select
   input  wire [3:0]  fault,       // miss, no access, read only, user attr
   output reg  [3:0]  xlat_ans,    // hit, no access, read only, user attr
   output reg  [18:0] arr_rdata    // array data
);
   wire [3:0] ans = {~fault[3], fault[2:0]};

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         xlat_ans  <= 4'h0;
         arr_rdata <= 19'h00000;
      end else begin
         // off the answer cycle the lookup lines show the inverse and the array data toggles each cycle, so a sample one cycle off fails
         xlat_ans  <= xlat_req_q ? ans : ~ans;
         arr_rdata <= arr_rd_q ? {arr_tag_q, arr_way_q, arr_class_q, arr_word_q, 6'h2D}
                               : ~arr_rdata;
      end
   end
endmodule

/* tb/dcm_monitor.sv */
// assertion checker for the class maintenance engine
`timescale 1ns/1ps
`include "dcm_consts.vh"

module dcm_monitor (
   input wire        clock,          // core clock
   input wire        arst_n,         // reset, low
   input wire [31:0] op_instr,       // instruction
   input wire [31:0] op_base_val,    // base value
   input wire [31:0] op_index_val,   // index value
   input wire        op_reloc_en,    // relocation
   input wire        busy_q,         // busy
   input wire        done_q,         // done
   input wire        exc_program_q,  // program fault
   input wire        exc_align_q,    // alignment fault
   input wire        exc_dstor_q,    // storage fault
   input wire        exc_dtlb_q,     // tlb miss
   input wire        dest_we_q,      // dest write
   input wire [31:0] dest_data_q,    // dest value
   input wire        xlat_req_q,     // lookup request
   input wire [31:0] xlat_ea_q,      // lookup address
   input wire        xlat_store_q,   // store class
   input wire        xlat_hit,       // translation found
   input wire        xlat_read_only, // read-only zone
   input wire        arr_rd_q,       // array read
   input wire [7:0]  arr_class_q,    // class
   input wire [2:0]  arr_word_q,     // word
   input wire [18:0] arr_rdata       // array data
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   // ==========================================================
   // sequences
   sequence s_inv_req;
      xlat_req_q && xlat_store_q;
   endsequence
   sequence s_tlb_miss;
      xlat_req_q ##1 (op_reloc_en && !xlat_hit);
   endsequence
   sequence s_zone_ro;
      s_inv_req ##1 (op_reloc_en && xlat_hit && xlat_read_only);
   endsequence

   // ==========================================================
   // assertions
   exc_with_done_a: assert property ((exc_program_q || exc_align_q || exc_dstor_q
      || exc_dtlb_q || dest_we_q) |-> done_q) else $error("fault or write without done");
   prog_idle_a: assert property (exc_program_q |-> !busy_q && !$past(busy_q))
      else $error("program fault after busy");
   inv_length_a: assert property (s_inv_req |=> !done_q ##1 done_q)
      else $error("invalidate length wrong");
   tlb_fault_a: assert property (s_tlb_miss |=> done_q && exc_dtlb_q)
      else $error("missing tlb fault");
   zone_fault_a: assert property (s_zone_ro |=> done_q && exc_dstor_q)
      else $error("missing storage fault");
   read_no_stor_a: assert property (xlat_req_q && !xlat_store_q |-> !exc_dstor_q [*5])
      else $error("storage fault on read");
   read_answer_a: assert property (arr_rd_q |-> ##2 (done_q && dest_we_q))
      else $error("read result late");
   result_place_a: assert property (dest_we_q |-> dest_data_q[31:13] == $past(arr_rdata)
      && dest_data_q[12:6] == 7'h00 && dest_data_q[3:1] == 3'h0) else $error("result layout");
   array_select_a: assert property (arr_rd_q |-> arr_class_q == xlat_ea_q[12:5]
      && arr_word_q == xlat_ea_q[4:2]) else $error("array select wrong");
   addr_form_a: assert property (xlat_req_q |-> xlat_ea_q == ((op_instr[20:16] == 5'h00)
      ? 32'h0 : op_base_val) + op_index_val && xlat_store_q == (op_instr[10:1] == `DCM_XO_INV))
      else $error("address or class wrong");
endmodule

bind dcm_top dcm_monitor u_dcm_monitor (.clock(clock), .arst_n(arst_n), .op_instr(op_instr),
   .op_base_val(op_base_val), .op_index_val(op_index_val), .op_reloc_en(op_reloc_en),
   .busy_q(busy_q), .done_q(done_q), .exc_program_q(exc_program_q), .exc_align_q(exc_align_q),
   .exc_dstor_q(exc_dstor_q), .exc_dtlb_q(exc_dtlb_q), .dest_we_q(dest_we_q),
   .dest_data_q(dest_data_q), .xlat_req_q(xlat_req_q), .xlat_ea_q(xlat_ea_q),
   .xlat_store_q(xlat_store_q), .xlat_hit(xlat_hit), .xlat_read_only(xlat_read_only),
   .arr_rd_q(arr_rd_q), .arr_class_q(arr_class_q), .arr_word_q(arr_word_q),
   .arr_rdata(arr_rdata));

/* tb/dcm_top_tb_top.sv */
// testbench for the class maintenance engine
`timescale 1ns/1ps
`include "dcm_consts.vh"

module dcm_top_tb_top;
   reg         clock, arst_n, reg_wr, reg_rd, op_valid, op_user_mode, op_reloc_en, upd_we;
   reg  [7:0]  reg_addr, upd_class;
   reg  [31:0] reg_wdata, op_instr, op_base_val, op_index_val;
   reg  [4:0]  upd_mask, upd_bits;
   reg  [3:0]  fault;
   wire [31:0] reg_rdata_q, dest_data_q, xlat_ea_q;
   wire        busy_q, done_q, exc_program_q, exc_align_q, exc_dstor_q, exc_dtlb_q;
   wire        dest_we_q, xlat_req_q, xlat_store_q, arr_rd_q, arr_way_q, arr_tag_q;
   wire [4:0]  dest_idx_q;
   wire [7:0]  arr_class_q;
   wire [2:0]  arr_word_q;
   wire [3:0]  xans;
   wire [18:0] arr_rdata;
   integer     fails, num_checks, i;

   dcm_top u_dcm_top (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
      .op_valid(op_valid), .op_instr(op_instr), .op_base_val(op_base_val),
      .op_index_val(op_index_val), .op_user_mode(op_user_mode), .op_reloc_en(op_reloc_en),
      .busy_q(busy_q), .done_q(done_q), .exc_program_q(exc_program_q),
      .exc_align_q(exc_align_q), .exc_dstor_q(exc_dstor_q), .exc_dtlb_q(exc_dtlb_q),
      .dest_we_q(dest_we_q), .dest_idx_q(dest_idx_q), .dest_data_q(dest_data_q),
      .xlat_req_q(xlat_req_q), .xlat_ea_q(xlat_ea_q), .xlat_store_q(xlat_store_q),
      .xlat_hit(xans[3]), .xlat_no_access(xans[2]), .xlat_read_only(xans[1]),
      .xlat_user_attr(xans[0]), .arr_rd_q(arr_rd_q), .arr_class_q(arr_class_q),
      .arr_way_q(arr_way_q), .arr_word_q(arr_word_q), .arr_tag_q(arr_tag_q),
      .arr_rdata(arr_rdata), .upd_we(upd_we), .upd_class(upd_class), .upd_mask(upd_mask),
      .upd_bits(upd_bits));

   dcm_far_model u_dcm_far_model (.clock(clock), .arst_n(arst_n), .xlat_req_q(xlat_req_q),
      .arr_rd_q(arr_rd_q), .arr_class_q(arr_class_q), .arr_way_q(arr_way_q),
      .arr_word_q(arr_word_q), .arr_tag_q(arr_tag_q), .fault(fault), .xlat_ans(xans),
      .arr_rdata(arr_rdata));

   always #10 clock = ~clock;

   // ==========================================================
   // helpers
   function [31:0] mk(input [4:0] rd, input [4:0] ra, input [9:0] xo);
      mk = {`DCM_OPC_PRI, rd, ra, 5'h00, xo, 1'b0};
   endfunction
   function [31:0] res(input t, input w, input [2:0] wd, input [1:0] dv);
      res = {t, w, 8'h12, wd, 6'h2D, 7'h00, dv, 3'h0, 1'b1};
   endfunction

   task chk(input [31:0] got, input [31:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            fails = fails + 1;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task wreg(input [7:0] a, input [31:0] d);
      begin
         @(posedge clock);
         {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
         @(posedge clock);
         reg_wr <= 1'b0;
      end
   endtask
   task rr(input [7:0] a, input [31:0] exp, input [31:0] msk);
      begin
         @(posedge clock);
         {reg_rd, reg_addr} <= {1'b1, a};
         @(posedge clock);
         reg_rd <= 1'b0;
         #1;
         chk(reg_rdata_q & msk, exp);
      end
   endtask
   // one issue, then wait for done; lat 8 means the word must be ignored
   task op(input [31:0] ins, input [31:0] b, input [31:0] x, input u, input r,
           input [3:0] lat, input [3:0] ex, input w, input [31:0] ed);
      integer n;
      begin
         @(posedge clock);
         {op_valid, op_instr, op_base_val, op_index_val, op_user_mode, op_reloc_en}
            <= {1'b1, ins, b, x, u, r};
         @(posedge clock);
         op_valid <= 1'b0;
         n = 1;
         #1;
         while (done_q !== 1'b1 && n < 8) begin
            @(posedge clock);
            #1;
            n = n + 1;
         end
         chk(n, lat);
         chk({exc_dtlb_q, exc_dstor_q, exc_align_q, exc_program_q}, ex);
         chk(dest_we_q, w);
         if (w) begin
            chk(dest_idx_q, ins[25:21]);
            chk(dest_data_q, ed);
         end
      end
   endtask
   task report_and_stop;
      begin
         $display("checks %0d fails %0d", num_checks, fails);
         if (fails == 0 && num_checks > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask

   initial begin
      #200000;
      fails = fails + 1;
      report_and_stop;
   end

   // ==========================================================
   // tests
   initial begin
      {clock, arst_n, reg_wr, reg_rd, op_valid, op_user_mode, op_reloc_en, upd_we} = 8'h00;
      {reg_addr, upd_class, upd_mask, upd_bits, fault} = 30'h0;
      {reg_wdata, op_instr, op_base_val, op_index_val} = 128'h0;
      fails = 0;
      num_checks = 0;
      repeat (3) @(posedge clock);
      arst_n <= 1'b1;
      rr(8'h00, 32'h0, 32'hFFFFFFFF);
      rr(8'h04, 32'h0, 32'hFFFFFFFF);
      wreg(8'h08, 32'h7);
      rr(8'h08, 32'h0, 32'hFFFFFFFF);
      rr(8'h00, 32'h0, 32'hFFFFFFFF);
      for (i = 0; i < 256; i = i + 1)
         op(mk(0, 0, `DCM_XO_INV), 32'hFFFFFFFF, i << 5, 0, 0, 3, 0, 0, 0);
      @(posedge clock);
      {upd_we, upd_class, upd_mask, upd_bits} <= {1'b1, 8'h12, 5'h1F, 5'h1D};
      @(posedge clock);
      upd_we <= 1'b0;
      op(mk(7, 3, `DCM_XO_READ), 32'h200, 32'h48, 0, 0, 5, 0, 1, res(0, 0, 2, 3));
      wreg(8'h00, 32'h3);
      op(mk(2, 0, `DCM_XO_READ), 32'hFFFFFFFF, 32'h240, 0, 0, 5, 0, 1, res(1, 1, 0, 2));
      op(mk(31, 3, `DCM_XO_INV), 32'h200, 32'h40, 0, 0, 3, 0, 0, 0);
      for (i = 0; i < 2; i = i + 1) begin
         wreg(8'h00, 2 + i);
         op(mk(4, 0, `DCM_XO_READ), 0, 32'h240, 0, 0, 5, 0, 1, res(1, i, 0, 0));
      end
      op(mk(0, 3, `DCM_XO_INV), 32'h200, 32'h40, 1, 0, 1, 1, 0, 0);
      op(mk(1, 3, `DCM_XO_READ), 32'h200, 32'h40, 1, 0, 1, 1, 0, 0);
      op(mk(1, 0, `DCM_XO_READ), 0, 32'h241, 0, 0, 1, 2, 0, 0);
      op(mk(1, 0, 10'h116), 0, 32'h240, 0, 0, 8, 0, 0, 0);
      op(mk(1, 0, `DCM_XO_READ) | 32'h1, 0, 32'h240, 0, 0, 8, 0, 0, 0);
      fault = 4'h8;
      op(mk(1, 0, `DCM_XO_READ), 0, 32'h240, 0, 1, 3, 8, 0, 0);
      op(mk(0, 0, `DCM_XO_INV), 0, 32'h240, 0, 1, 3, 8, 0, 0);
      fault = 4'h2;
      op(mk(0, 0, `DCM_XO_INV), 0, 32'h240, 0, 1, 3, 4, 0, 0);
      rr(8'h04, 32'h08, 32'h1F);
      op(mk(5, 0, `DCM_XO_READ), 0, 32'h240, 0, 1, 5, 0, 1, res(1, 1, 0, 0));
      fault = 4'h4;
      op(mk(0, 0, `DCM_XO_INV), 0, 32'h240, 0, 1, 3, 0, 0, 0);
      fault = 4'h1;
      op(mk(0, 0, `DCM_XO_INV), 0, 32'h240, 0, 1, 3, 0, 0, 0);
      wreg(8'h00, 32'h4);
      op(mk(0, 0, `DCM_XO_INV), 0, 32'h240, 0, 1, 3, 4, 0, 0);
      op(mk(6, 0, `DCM_XO_READ), 0, 32'h248, 0, 1, 5, 0, 1, res(0, 0, 2, 0));
      report_and_stop;
   end
endmodule
